/* src/mmd_decode.sv */
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
// Operation
// - 2K RAM, base zero, relocatable 2K
// - RAM field gives base bits 15:11
// - Register block hides lowest 512 RAM bytes
// - Mapping registers write-once normal, anytime special
// - 1K EEPROM at 0C00, 4K relocatable
// - EEPROM enable; forced on single-chip
// - Swap bit exchanges the two arrays
// - Narrow bit: window uses 8-bit bus
// - Window follows register block, 512 bytes
// - Window stretch 0 to 3 E-clocks
// - External stretch 0 to 3 E-clocks
// - Array enables place arrays in map
// - RAM misaligned word in one cycle
// - Strobe, A0, read/write encode access type
// - Peripheral mode drops first 16 registers
// - Expanded modes externalise port A/B registers
// - Port E emulation externalises port E
// - Port A carries high address byte or I/O
// - Port A direction: 0 input, 1 output
// - Mapping writes take effect one cycle later
// - Decode priority debug, regs, RAM, EEPROM, arrays
module mmd_decode #(
  parameter int ECLK_DIV = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [mmd_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [mmd_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] mode_pins,
  input wire logic port_e_emulation,
  input wire logic debug_active,
  input wire logic [4:0] reg_base,
  input wire logic cpu_req,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_write,
  input wire logic cpu_wide,
  output logic cpu_done,
  output logic [6:0] target,
  output logic in_window,
  output logic ext_narrow,
  output logic [15:0] bus_addr,
  output logic byte_strobe_n,
  output logic bus_rw,
  output logic swap_halves,
  input wire logic [7:0] port_a_pins_in,
  output logic [7:0] port_a_pins_out,
  output logic [7:0] port_a_pins_oe
);
  import mmd_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and mode strap
  // ----------------------------------------------------------------
  logic [2:0] mode_s1_r, mode_s2_r, mode_r, mode_nxt;
  logic [7:0] pa_s1_r, pa_s2_r;
  logic mode_taken_r;
  logic single, periph, expanded, wide_exp, special;

  always_comb begin
    mode_nxt = mode_taken_r ? mode_r : mode_s2_r;
  end

  always_ff @(posedge core_clk) begin
    mode_s1_r <= mode_pins;
    mode_s2_r <= mode_s1_r;
    pa_s1_r <= port_a_pins_in;
    pa_s2_r <= pa_s1_r;
    if (!rst_n) begin
      mode_r <= RST_MODE;
      mode_taken_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      mode_taken_r <= 1'b1;
    end
  end

  assign special = !mode_r[MODE_SMODN];
  assign expanded = mode_r[MODE_MODA];
  assign single = !mode_r[MODE_MODA] && !mode_r[MODE_MODB];
  assign periph = special && mode_r[MODE_MODB] && !mode_r[MODE_MODA];
  assign wide_exp = expanded && mode_r[MODE_MODB];

  // ----------------------------------------------------------------
  // Register bus and mapping registers
  // ----------------------------------------------------------------
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [5:0] aw_idx_r, aw_idx_nxt;
  logic [7:0] wbyte_r, wbyte_nxt;
  logic wlane_r, wlane_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] pa_r, pa_nxt, pdir_r, pdir_nxt;
  logic [7:0] ram_r, ram_nxt, ee_r, ee_nxt, misc_r, misc_nxt;
  logic [2:0] once_r, once_nxt;
  logic [7:0] act_ram_r, act_ee_r, act_misc_r;
  logic [7:0] ee_view;
  logic [5:0] ar_idx;
  logic bus_busy;
  logic awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;

  function automatic logic known_idx(input logic [5:0] idx, input logic ports_on);
    known_idx = ((idx == IDX_PA_DATA || idx == IDX_PA_DIR) && ports_on) ||
                idx == IDX_RAM_POS || idx == IDX_EE_POS || idx == IDX_MISC || idx == IDX_STATUS;
  endfunction

  assign ar_idx = s_axi_araddr[AXI_AW-1:2];
  assign ee_view = single ? (ee_r | 8'h01) : ee_r;

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_idx_nxt = aw_idx_r;
    w_hold_nxt = w_hold_r;
    wbyte_nxt = wbyte_r;
    wlane_nxt = wlane_r;
    bvalid_nxt = bvalid_r && !s_axi_bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !s_axi_rready;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    pa_nxt = pa_r;
    pdir_nxt = pdir_r;
    ram_nxt = ram_r;
    ee_nxt = ee_r;
    misc_nxt = misc_r;
    once_nxt = once_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      aw_idx_nxt = s_axi_awaddr[AXI_AW-1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      wbyte_nxt = s_axi_wdata[7:0];
      wlane_nxt = s_axi_wstrb[0];
    end
    if (aw_hold_r && w_hold_r && !bvalid_r) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = known_idx(aw_idx_r, single) ? RESP_OKAY : RESP_SLVERR;
      if (wlane_r) begin
        case (aw_idx_r)
          IDX_PA_DATA: if (single) pa_nxt = wbyte_r;
          IDX_PA_DIR: if (single) pdir_nxt = wbyte_r;
          IDX_RAM_POS: if (special || !once_r[0]) begin
            ram_nxt = wbyte_r;
            once_nxt[0] = 1'b1;
          end
          IDX_EE_POS: if (special || !once_r[1]) begin
            ee_nxt = wbyte_r;
            once_nxt[1] = 1'b1;
          end
          IDX_MISC: if (special || !once_r[2]) begin
            misc_nxt = wbyte_r;
            once_nxt[2] = 1'b1;
          end
          default: ;
        endcase
      end
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = known_idx(ar_idx, single) ? RESP_OKAY : RESP_SLVERR;
      case (ar_idx)
        IDX_PA_DATA: rdata_nxt = (pa_r & pdir_r) | (pa_s2_r & ~pdir_r);
        IDX_PA_DIR: rdata_nxt = pdir_r;
        IDX_RAM_POS: rdata_nxt = ram_r;
        IDX_EE_POS: rdata_nxt = ee_view;
        IDX_MISC: rdata_nxt = misc_r;
        IDX_STATUS: rdata_nxt = {3'h0, bus_busy, once_r, 1'b0} | {5'h00, mode_r} << 5;
        default: rdata_nxt = 8'h00;
      endcase
      if (!known_idx(ar_idx, single)) begin
        rdata_nxt = 8'h00;
      end
    end
    // Ready is registered so that every bus output comes straight from a flop.
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt = !w_hold_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  // Mapping values reach the decoder one cycle after the write lands.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_hold_r <= 1'b0;
      aw_idx_r <= 6'h00;
      w_hold_r <= 1'b0;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 8'h00;
      pa_r <= RST_PA;
      pdir_r <= RST_PA;
      ram_r <= RST_RAM_POS;
      ee_r <= RST_EE_POS;
      misc_r <= RST_MISC;
      once_r <= 3'h0;
      act_ram_r <= RST_RAM_POS;
      act_ee_r <= RST_EE_POS;
      act_misc_r <= RST_MISC;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      aw_idx_r <= aw_idx_nxt;
      w_hold_r <= w_hold_nxt;
      wbyte_r <= wbyte_nxt;
      wlane_r <= wlane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      pa_r <= pa_nxt;
      pdir_r <= pdir_nxt;
      ram_r <= ram_nxt;
      ee_r <= ee_nxt;
      misc_r <= misc_nxt;
      once_r <= once_nxt;
      act_ram_r <= ram_r;
      act_ee_r <= ee_view;
      act_misc_r <= misc_r;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = {24'h000000, rdata_r};

  // ----------------------------------------------------------------
  // Address decode and bus cycle
  // ----------------------------------------------------------------
  logic [6:0] hit;
  logic win_hit, narrow_hit, misaligned, port_gone;
  logic [8:0] reg_ofs;
  logic [1:0] str_code;
  logic [15:0] ram_base, ee_base;
  mmd_bus_e st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [6:0] target_r, target_nxt;
  logic win_r, win_nxt, narrow_r, narrow_nxt, done_r, done_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic strobe_n_r, strobe_n_nxt, rw_r, rw_nxt, swap_r, swap_nxt;
  logic [7:0] pa_out_r, pa_out_nxt, pa_oe_r, pa_oe_nxt;

  assign reg_ofs = cpu_addr[8:0];
  assign ram_base = {act_ram_r[RAM_POS_LSB+:5], 11'h000};
  assign ee_base = {act_ee_r[EE_POS_LSB+:4], EE_SUB_BLOCK, 10'h000};
  assign bus_busy = (st_r == BUS_HOLD);

  always_comb begin
    hit = 7'h00;
    hit[T_DEBUG] = debug_active && cpu_addr >= DEBUG_BASE;
    hit[T_REGS] = cpu_addr[15:11] == reg_base && !cpu_addr[10] && !cpu_addr[9];
    // Externalised port registers must reach the bus even where RAM overlaps them.
    port_gone = 1'b0;
    if (expanded && reg_ofs <= OFS_PORT_LAST) begin
      port_gone = hit[T_REGS];
      hit[T_REGS] = 1'b0;
    end
    if (expanded && port_e_emulation && (reg_ofs == OFS_PE_DATA || reg_ofs == OFS_PE_DIR)) begin
      port_gone = hit[T_REGS];
      hit[T_REGS] = 1'b0;
    end
    if (periph && reg_ofs <= OFS_EXPAND_LAST) begin
      hit[T_REGS] = 1'b0;
    end
    win_hit = cpu_addr[15:11] == reg_base && !cpu_addr[10] && cpu_addr[9];
    hit[T_RAM] = cpu_addr[15:11] == ram_base[15:11];
    hit[T_EEPROM] = act_ee_r[EE_ON_BIT] && cpu_addr[15:10] == ee_base[15:10];
    if (act_misc_r[MISC_SWAP]) begin
      hit[T_SMALL] = cpu_addr >= SMALL_LO_S;
      hit[T_LARGE] = cpu_addr <= HALF_TOP;
    end else begin
      hit[T_SMALL] = cpu_addr >= SMALL_LO_N && cpu_addr <= HALF_TOP;
      hit[T_LARGE] = cpu_addr >= LARGE_LO_N;
    end
    hit[T_SMALL] = hit[T_SMALL] && act_misc_r[MISC_SMALL_EN];
    hit[T_LARGE] = hit[T_LARGE] && act_misc_r[MISC_LARGE_EN];
    hit[T_EXT] = 1'b1;
    target_nxt = 7'h00;
    if (hit[T_DEBUG]) target_nxt[T_DEBUG] = 1'b1;
    else if (hit[T_REGS]) target_nxt[T_REGS] = 1'b1;
    else if (port_gone) target_nxt[T_EXT] = 1'b1;
    else if (hit[T_RAM]) target_nxt[T_RAM] = 1'b1;
    else if (hit[T_EEPROM]) target_nxt[T_EEPROM] = 1'b1;
    else if (hit[T_SMALL]) target_nxt[T_SMALL] = 1'b1;
    else if (hit[T_LARGE]) target_nxt[T_LARGE] = 1'b1;
    else target_nxt[T_EXT] = 1'b1;
    narrow_hit = (expanded && !mode_r[MODE_MODB]) ||
                 (wide_exp && win_hit && act_misc_r[MISC_NARROW]);
    str_code = win_hit ? act_misc_r[MISC_WSTR+:2] : act_misc_r[MISC_XSTR+:2];
    misaligned = cpu_wide && cpu_addr[0];
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    win_nxt = win_r;
    narrow_nxt = narrow_r;
    addr_nxt = addr_r;
    strobe_n_nxt = strobe_n_r;
    rw_nxt = rw_r;
    swap_nxt = swap_r;
    done_nxt = 1'b0;
    case (st_r)
      BUS_IDLE: begin
        if (cpu_req) begin
          addr_nxt = cpu_addr;
          rw_nxt = !cpu_write;
          strobe_n_nxt = !(cpu_wide ^ cpu_addr[0]);
          swap_nxt = misaligned && target_nxt[T_RAM];
          win_nxt = win_hit && target_nxt[T_EXT];
          narrow_nxt = narrow_hit && target_nxt[T_EXT];
          if (target_nxt[T_EXT] && expanded && !periph) begin
            st_nxt = BUS_HOLD;
            cnt_nxt = 4'((32'(str_code) + 1) * ECLK_DIV - 1);
          end else begin
            done_nxt = 1'b1;
          end
        end else begin
          target_nxt = 7'h00;
        end
      end
      BUS_HOLD: begin
        target_nxt = target_r;
        if (cnt_r == 4'h0) begin
          st_nxt = BUS_IDLE;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: st_nxt = BUS_IDLE;
    endcase
    if (single) begin
      pa_out_nxt = pa_r;
      pa_oe_nxt = pdir_r;
    end else begin
      pa_out_nxt = addr_nxt[15:8];
      pa_oe_nxt = {8{st_nxt == BUS_HOLD}};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= BUS_IDLE;
      cnt_r <= 4'h0;
      target_r <= 7'h00;
      win_r <= 1'b0;
      narrow_r <= 1'b0;
      addr_r <= 16'h0000;
      strobe_n_r <= 1'b1;
      rw_r <= 1'b1;
      swap_r <= 1'b0;
      done_r <= 1'b0;
      pa_out_r <= 8'h00;
      pa_oe_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      target_r <= target_nxt;
      win_r <= win_nxt;
      narrow_r <= narrow_nxt;
      addr_r <= addr_nxt;
      strobe_n_r <= strobe_n_nxt;
      rw_r <= rw_nxt;
      swap_r <= swap_nxt;
      done_r <= done_nxt;
      pa_out_r <= pa_out_nxt;
      pa_oe_r <= pa_oe_nxt;
    end
  end

  assign target = target_r;
  assign in_window = win_r;
  assign ext_narrow = narrow_r;
  assign bus_addr = addr_r;
  assign byte_strobe_n = strobe_n_r;
  assign bus_rw = rw_r;
  assign swap_halves = swap_r;
  assign cpu_done = done_r;
  assign port_a_pins_out = pa_out_r;
  assign port_a_pins_oe = pa_oe_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_once_lock: assert property (!special && $past(once_r[0]) && s_axi_bvalid && !$past(s_axi_bvalid)
    |-> ram_r == $past(ram_r)) else $error("ram position changed after first write");
  a_map_delay: assert property ($changed(ram_r) |=> act_ram_r == $past(ram_r))
    else $error("ram position not applied one cycle later");
  a_ee_forced: assert property (single |=> act_ee_r[EE_ON_BIT])
    else $error("eeprom not forced on in single chip");
  a_onehot_target: assert property (cpu_done |-> $onehot(target))
    else $error("target not one-hot");
  a_strobe_code: assert property (st_r == BUS_IDLE && cpu_req ##1 1'b1
    |-> byte_strobe_n == !($past(cpu_wide) ^ $past(cpu_addr[0]))) else $error("bad strobe code");
  a_swap_ram: assert property (swap_halves && cpu_done |-> target[T_RAM])
    else $error("swap outside ram");
  a_hold_stable: assert property (bus_busy && $past(bus_busy) |-> $stable(bus_addr) && $stable(bus_rw))
    else $error("address moved during stretch");
  a_int_one_cycle: assert property (st_r == BUS_IDLE && cpu_req && !target_nxt[T_EXT] |=> cpu_done)
    else $error("internal access not done in one cycle");
  a_stretch_len: assert property (st_r == BUS_IDLE && st_nxt == BUS_HOLD && str_code == 2'h3
    |=> bus_busy [*4]) else $error("stretch too short");
  a_pa_dir: assert property (single |=> port_a_pins_oe == $past(pdir_r))
    else $error("port a enable does not follow direction");
  a_periph_drop: assert property (periph && cpu_req && st_r == BUS_IDLE && reg_ofs <= OFS_EXPAND_LAST
    |-> !target_nxt[T_REGS]) else $error("peripheral mode register still mapped");
  c_ext_stretch: cover property (bus_busy ##1 cpu_done);
  c_ram_swap: cover property (cpu_done && swap_halves);
  c_axi_write: cover property (s_axi_bvalid && s_axi_bready);

endmodule // mmd_decode

/* inc/mmd_pkg.sv */
package mmd_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [5:0] IDX_PA_DATA = 6'h00;
  localparam logic [5:0] IDX_PA_DIR = 6'h02;
  localparam logic [5:0] IDX_RAM_POS = 6'h10;
  localparam logic [5:0] IDX_EE_POS = 6'h12;
  localparam logic [5:0] IDX_MISC = 6'h13;
  localparam logic [5:0] IDX_STATUS = 6'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PA = 8'h00;
  localparam logic [7:0] RST_RAM_POS = 8'h00;
  localparam logic [7:0] RST_EE_POS = 8'h01;
  localparam logic [7:0] RST_MISC = 8'h1B;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam int RAM_POS_LSB = 3;
  localparam int EE_POS_LSB = 4;
  localparam int EE_ON_BIT = 0;
  localparam int MISC_NARROW = 7;
  localparam int MISC_WSTR = 5;
  localparam int MISC_XSTR = 3;
  localparam int MISC_SWAP = 2;
  localparam int MISC_SMALL_EN = 1;
  localparam int MISC_LARGE_EN = 0;
  localparam int MODE_SMODN = 2;
  localparam int MODE_MODB = 1;
  localparam int MODE_MODA = 0;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [1:0] EE_SUB_BLOCK = 2'h3;
  localparam logic [15:0] DEBUG_BASE = 16'hFF00;
  localparam logic [15:0] SMALL_LO_N = 16'h1000;
  localparam logic [15:0] SMALL_LO_S = 16'h9000;
  localparam logic [15:0] LARGE_LO_N = 16'h8000;
  localparam logic [15:0] HALF_TOP = 16'h7FFF;
  localparam logic [8:0] OFS_PE_DATA = 9'h008;
  localparam logic [8:0] OFS_PE_DIR = 9'h009;
  localparam logic [8:0] OFS_PORT_LAST = 9'h003;
  localparam logic [8:0] OFS_EXPAND_LAST = 9'h00F;

  // ----------------------------------------------------------------
  // Target one-hot positions
  // ----------------------------------------------------------------
  localparam int T_DEBUG = 0;
  localparam int T_REGS = 1;
  localparam int T_RAM = 2;
  localparam int T_EEPROM = 3;
  localparam int T_SMALL = 4;
  localparam int T_LARGE = 5;
  localparam int T_EXT = 6;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_HOLD = 1'b1
  } mmd_bus_e;

endpackage

/* test/mmd_ext_model.sv */
`timescale 1ns/1ns
// ----
// Far-side access decoder
// ----
module mmd_ext_model (
  input wire logic [15:0] bus_addr,
  input wire logic byte_strobe_n,
  input wire logic bus_rw,
  output logic [1:0] access_kind,
  output logic is_read
);
  // Kind 0 even byte, 1 odd byte, 2 even word, 3 odd word with halves swapped.
  // A peripheral needs only the strobe and A0 to size the cycle, so no state is kept.
  always_comb begin
    access_kind = {~(byte_strobe_n ^ bus_addr[0]), bus_addr[0]};
    is_read = bus_rw;
  end
endmodule // mmd_ext_model

/* test/mmd_tb_top.sv */
`timescale 1ns/1ns
module mmd_tb_top;
  import mmd_pkg::*;
  // ----
  // Signals
  // ----
  localparam int ECLK = 2;
  logic core_clk;
  logic rst_n = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [2:0] mode_pins = 3'h3;
  logic dbg = 1'h0;
  logic req = 1'h0;
  logic wr = 1'h0;
  logic wide = 1'h0;
  logic [15:0] addr = 16'h0;
  logic pe_emu = 1'h0;
  logic [4:0] rbase = 5'h00;
  logic [7:0] pa_in = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, done, in_window, ext_narrow, strobe_n, bus_rw, swap_h, is_rd;
  logic [1:0] bresp, rresp, kind, r;
  logic [31:0] rdata, d;
  logic [6:0] target;
  logic [15:0] bus_addr;
  logic [7:0] pa_out, pa_oe;
  int mismatches = 0;
  int tests_run = 0;

  mmd_decode #(.ECLK_DIV(ECLK)) i_mmd_decode (
    .core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mode_pins(mode_pins),
    .port_e_emulation(pe_emu), .debug_active(dbg), .reg_base(rbase), .cpu_req(req), .cpu_addr(addr),
    .cpu_write(wr), .cpu_wide(wide), .cpu_done(done), .target(target), .in_window(in_window),
    .ext_narrow(ext_narrow), .bus_addr(bus_addr), .byte_strobe_n(strobe_n), .bus_rw(bus_rw),
    .swap_halves(swap_h), .port_a_pins_in(pa_in), .port_a_pins_out(pa_out), .port_a_pins_oe(pa_oe)
  );

  mmd_ext_model i_mmd_ext_model (
    .bus_addr(bus_addr), .byte_strobe_n(strobe_n), .bus_rw(bus_rw), .access_kind(kind), .is_read(is_rd)
  );

  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end

  // ----
  // Tasks
  // ----
  task automatic final_report();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    mismatches++;
    $display("wrong value at %0t: no answer", $time);
    final_report();
  endtask

  task automatic do_reset(input logic [2:0] m);
    @(posedge core_clk);
    rst_n <= 1'h0;
    mode_pins <= m;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [7:0] v);
    int i;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) break;
    end
    if (i == 20) hang();
    r = bresp;
    bready <= 1'h0;
    // Mapping writes reach the decoder one edge after the response.
    repeat (3) @(posedge core_clk);
  endtask

  task automatic axr(input logic [7:0] a);
    int i;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) break;
    end
    if (i == 20) hang();
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task automatic acc(input logic [15:0] a, input logic w, input logic wd, input int t, input int l);
    int n;
    @(posedge core_clk);
    addr <= a;
    wr <= w;
    wide <= wd;
    req <= 1'h1;
    @(posedge core_clk);
    req <= 1'h0;
    // Internal hits finish first, so only stretched cycles reach the address check.
    for (n = 1; n < 40; n++) begin
      @(posedge core_clk);
      if (done === 1'h1) break;
      if (n > 1) check(32'(bus_addr), 32'(a));
    end
    if (n == 40) hang();
    check(32'(target), 32'h1 << t);
    check(n, l);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_resets();
    logic [7:0] ad [5] = '{8'h40, 8'h48, 8'h4C, 8'h60, 8'h00};
    logic [7:0] ex [5] = '{RST_RAM_POS, RST_EE_POS, RST_MISC, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      axr(ad[i]);
      check(d, 32'(ex[i]));
      check(32'(r), (i > 2) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY));
    end
  endtask

  task automatic t_default();
    logic [15:0] a [6] = '{16'h0010, 16'h01FF, 16'h0200, 16'h0C00, 16'h1000, 16'h8000};
    int t [6] = '{T_REGS, T_REGS, T_RAM, T_EEPROM, T_SMALL, T_LARGE};
    for (int i = 0; i < 6; i++) acc(a[i], 1'h0, 1'h0, t[i], 1);
    acc(16'h0002, 1'h0, 1'h0, T_EXT, 4 * ECLK + 1);
    dbg <= 1'h1;
    acc(16'hFF10, 1'h0, 1'h0, T_DEBUG, 1);
    dbg <= 1'h0;
  endtask

  task automatic t_reloc();
    axw(8'h40, 8'h20);
    axw(8'h48, 8'h31);
    acc(16'h2000, 1'h0, 1'h0, T_RAM, 1);
    acc(16'h27FF, 1'h0, 1'h0, T_RAM, 1);
    acc(16'h2800, 1'h0, 1'h0, T_SMALL, 1);
    acc(16'h3C00, 1'h0, 1'h0, T_EEPROM, 1);
    acc(16'h0C00, 1'h0, 1'h0, T_EXT, 4 * ECLK + 1);
    acc(16'h0200, 1'h0, 1'h0, T_EXT, ECLK + 1);
    check(32'(in_window), 32'h1);
    check(32'(ext_narrow), 32'h0);
    rbase <= 5'h01;
    pe_emu <= 1'h1;
    acc(16'h0A00, 1'h0, 1'h0, T_EXT, ECLK + 1);
    check(32'(in_window), 32'h1);
    acc(16'h0810, 1'h0, 1'h0, T_REGS, 1);
    acc(16'h0808, 1'h0, 1'h0, T_EXT, 4 * ECLK + 1);
    check(32'(in_window), 32'h0);
    rbase <= 5'h00;
    pe_emu <= 1'h0;
    axw(8'h48, 8'h30);
    acc(16'h3C00, 1'h0, 1'h0, T_SMALL, 1);
    axr(8'h48);
    check(d, 32'h30);
  endtask

  task automatic t_stretch();
    for (int s = 0; s < 4; s++) begin
      axw(8'h4C, 8'h03 | 8'(s << 3));
      acc(16'h0400, 1'h1, 1'h1, T_EXT, (s + 1) * ECLK + 1);
      check(32'(kind), 32'h2);
      check(32'(is_rd), 32'h0);
    end
    axw(8'h4C, 8'hE3);
    acc(16'h0301, 1'h0, 1'h0, T_EXT, 4 * ECLK + 1);
    check(32'(ext_narrow), 32'h1);
    check(32'(kind), 32'h1);
    check(32'(is_rd), 32'h1);
  endtask

  task automatic t_swap();
    axw(8'h4C, 8'h07);
    acc(16'h1000, 1'h0, 1'h0, T_LARGE, 1);
    acc(16'h0400, 1'h0, 1'h0, T_LARGE, 1);
    acc(16'h9000, 1'h0, 1'h0, T_SMALL, 1);
    acc(16'h8FFF, 1'h0, 1'h0, T_EXT, ECLK + 1);
    axw(8'h4C, 8'h04);
    acc(16'h1000, 1'h0, 1'h0, T_EXT, ECLK + 1);
    acc(16'h9000, 1'h0, 1'h0, T_EXT, ECLK + 1);
    acc(16'h2001, 1'h0, 1'h1, T_RAM, 1);
    check(32'(swap_h), 32'h1);
    check(32'(kind), 32'h3);
    acc(16'h2000, 1'h1, 1'h1, T_RAM, 1);
    check(32'(swap_h), 32'h0);
  endtask

  task automatic t_modes();
    do_reset(3'h2);
    acc(16'h0005, 1'h0, 1'h0, T_RAM, 1);
    acc(16'h0010, 1'h0, 1'h0, T_REGS, 1);
    do_reset(3'h1);
    acc(16'h0800, 1'h0, 1'h0, T_EXT, 4 * ECLK + 1);
    check(32'(ext_narrow), 32'h1);
  endtask

  task automatic t_single();
    pa_in <= 8'hC3;
    axw(8'h08, 8'hA5);
    axw(8'h00, 8'h3C);
    check(32'(pa_oe), 32'hA5);
    check(32'(pa_out), 32'h3C);
    axr(8'h08);
    check(d, 32'hA5);
    axr(8'h00);
    check(d, 32'h66);
    axw(8'h48, 8'h30);
    acc(16'h3C00, 1'h0, 1'h0, T_EEPROM, 1);
  endtask

  task automatic t_normal();
    axw(8'h40, 8'h20);
    axw(8'h40, 8'h40);
    check(32'(r), 32'(RESP_OKAY));
    axr(8'h40);
    check(d, 32'h20);
    axr(8'h00);
    check(32'(r), 32'(RESP_SLVERR));
  endtask

  initial begin
    do_reset(3'h3);
    t_resets();
    t_default();
    t_reloc();
    t_stretch();
    t_swap();
    t_modes();
    do_reset(3'h0);
    t_single();
    do_reset(3'h7);
    t_normal();
    final_report();
  end
endmodule // mmd_tb_top
